// >>> sra_pkg.sv
// Shared constants for the special register access unit.
package sra_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PRI_W  = 8;
  localparam int unsigned EXP_W  = 10;

  // ------------------------------------------------------------
  // Selector groups (selector bits 7:3) and members (bits 2:0)
  // ------------------------------------------------------------
  localparam logic [4:0] GRP_STATUS = 5'h00;
  localparam logic [4:0] GRP_STACK  = 5'h01;
  localparam logic [4:0] GRP_MASK   = 5'h02;
  localparam logic [2:0] IDX_MAIN   = 3'h0;
  localparam logic [2:0] IDX_PROC   = 3'h1;
  localparam logic [2:0] IDX_BOOST  = 3'h0;
  localparam logic [2:0] IDX_BASE   = 3'h1;
  localparam logic [2:0] IDX_COND   = 3'h2;
  localparam logic [2:0] IDX_FAULT  = 3'h3;
  localparam logic [2:0] IDX_CTRL   = 3'h4;

  // ------------------------------------------------------------
  // Full selector values
  // ------------------------------------------------------------
  localparam logic [7:0] SEL_FLAGS  = 8'h00;
  localparam logic [7:0] SEL_FULL   = 8'h03;
  localparam logic [7:0] SEL_INT    = 8'h05;
  localparam logic [7:0] SEL_EXEC   = 8'h07;
  localparam logic [7:0] SEL_MSP    = 8'h08;
  localparam logic [7:0] SEL_PSP    = 8'h09;
  localparam logic [7:0] SEL_BOOST  = 8'h10;
  localparam logic [7:0] SEL_CTRL   = 8'h14;

  // ------------------------------------------------------------
  // Destinations that make a read unpredictable
  // ------------------------------------------------------------
  localparam logic [3:0] RD_SP = 4'hd;
  localparam logic [3:0] RD_PC = 4'hf;

  // ------------------------------------------------------------
  // Field positions in the read result
  // ------------------------------------------------------------
  localparam int unsigned FLAGS_HI = 31;
  localparam int unsigned FLAGS_LO = 27;
  localparam int unsigned INT_HI   = 8;

  // ------------------------------------------------------------
  // Reset values and priority levels
  // ------------------------------------------------------------
  localparam logic             BOOST_RST = 1'b0;
  localparam logic [7:0]       BASE_RST  = 8'h00;
  localparam logic             FAULT_RST = 1'b0;
  localparam logic [1:0]       CTRL_RST  = 2'h0;
  localparam logic signed [9:0] PRI_HARD  = 10'sh3ff;
  localparam logic signed [9:0] PRI_BOOST = 10'sh000;

endpackage : sra_pkg

// >>> sra_preempt_cmp.sv
// Pre-emption compare of the base priority mask against a priority level.
`timescale 1ns/1ps

module sra_preempt_cmp (
  // Priorities
  input  wire logic [7:0] base_pri,
  input  wire logic [7:0] stream_pri,
  // Grouping point
  input  wire logic [2:0] group_point,
  // Result
  output logic            masked
);

  logic [7:0] keep;

  // ------------------------------------------------------------
  // Pre-emption field select
  // ------------------------------------------------------------
  // Bits at or below the grouping point are sub-priority and never take part, except bit 7, which always takes part.
  for (genvar i = 0; i < 8; i++) begin : g_keep
    assign keep[i] = (3'(i) > group_point) || (i == 7);
  end

  // Zero in the base register disables masking altogether.
  assign masked = (base_pri != 8'h00) &&
                  ((stream_pri & keep) > (base_pri & keep));

endmodule : sra_preempt_cmp

// >>> sra_unit.sv
// Special register access unit: mask change, special read, mask writes.
`timescale 1ns/1ps
//
// Summary of operation
// - Effect bit 0 clears the chosen masks, effect bit 1 sets them.
// - Privileged clear form clears interrupt and fault masks as flagged.
// - Set form sets interrupt mask; fault mask only above hard fault level.
// - Unprivileged attempts to change either mask are ignored.
// - Read is unpredictable for destination 13 or 15 or unused selectors.
// - Selectors 0-3 and 5-7 read status views; 3 is the full composite.
// - Result starts at zero; bit 0 plus privilege places interrupt status.
// - Every status selector reads execution status as zero in 26:24 and 15:10.
// - Selector bit 2 clear copies condition flags into bits 31:27.
// - Selectors 8 and 9 give stack pointers when privileged, else zero.
// - Selector 16 reads interrupt mask when privileged; set mask raises priority to 0.
// - Selector 17 reads base priority when privileged; zero disables it.
// - Nonzero base priority masks only numerically higher priority levels.
// - Base priority compares the pre-emption part of the priority and always bit 7.
// - Selector 18 reads as the base priority register.
// - Writes through selector 18 are conditional.
// - Conditional write accepts when current is 0 or new is lower; never 0.
// - Selector 19 reads fault mask when privileged; set mask raises priority to -1.
// - Fault mask clears on non-NMI exception return; set above -1 only.
// - Selector 20 reads control bits 1:0 in any mode; bit 0 resets to 0.
// - Control bit 1 picks the stack; handler mode cannot set it.

module sra_unit (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // Mask change instruction
  input  wire logic              mask_change_valid,
  input  wire logic              effect_bit,
  input  wire logic              interrupt_mask_flag,
  input  wire logic              fault_mask_flag,
  // Special read instruction
  input  wire logic              read_valid,
  input  wire logic [3:0]        read_dest,
  input  wire logic [7:0]        read_sel,
  // Special write instruction, mask and control targets
  input  wire logic              write_valid,
  input  wire logic [7:0]        write_sel,
  input  wire logic [31:0]       write_data,
  // Core context
  input  wire logic              privileged,
  input  wire logic              handler_mode,
  input  wire logic signed [9:0] exec_priority,
  input  wire logic              exc_return,
  input  wire logic              exc_return_nmi,
  input  wire logic [4:0]        flags_in,
  input  wire logic [8:0]        int_status,
  input  wire logic [31:0]       main_sp,
  input  wire logic [31:0]       process_sp,
  input  wire logic [2:0]        group_point,
  input  wire logic [7:0]        stream_priority,
  // Read result
  output logic [31:0]            read_data,
  output logic                   read_done,
  output logic                   read_unpredictable,
  // Mask and control state
  output logic                   priority_boost_mask,
  output logic [7:0]             base_priority_mask,
  output logic                   fault_level_mask,
  output logic [1:0]             special_control,
  // Priority effects
  output logic                   ceiling_active,
  output logic signed [9:0]      ceiling_level,
  output logic                   base_masking
);

  logic              boost_q;
  logic              boost_d;
  logic [7:0]        base_q;
  logic [7:0]        base_d;
  logic              fault_q;
  logic              fault_d;
  logic [1:0]        ctrl_q;
  logic [1:0]        ctrl_d;
  logic [31:0]       rdata_q;
  logic [31:0]       rdata_d;
  logic              done_q;
  logic              done_d;
  logic              unpred_q;
  logic              unpred_d;
  logic              ceil_act_q;
  logic              ceil_act_d;
  logic signed [9:0] ceil_lvl_q;
  logic signed [9:0] ceil_lvl_d;
  logic              bmask_q;
  logic              bmask_d;
  logic              cmp_masked;
  logic              above_hard;
  logic [7:0]        new_pri;

  assign above_hard = exec_priority > sra_pkg::PRI_HARD;
  assign new_pri    = write_data[7:0];

  // ------------------------------------------------------------
  // Base priority masking compare
  // ------------------------------------------------------------
  sra_preempt_cmp u_cmp (
    .base_pri    (base_q),
    .stream_pri  (stream_priority),
    .group_point (group_point),
    .masked      (cmp_masked)
  );

  // ------------------------------------------------------------
  // Mask and control next state
  // ------------------------------------------------------------
  // The return clear is applied first so that a set in the same cycle wins.
  always_comb begin
    boost_d = boost_q;
    base_d  = base_q;
    fault_d = fault_q;
    ctrl_d  = ctrl_q;
    if (exc_return && !exc_return_nmi) begin
      fault_d = 1'b0;
    end
    if (mask_change_valid && privileged) begin
      if (!effect_bit) begin
        if (interrupt_mask_flag) begin
          boost_d = 1'b0;
        end
        if (fault_mask_flag) begin
          fault_d = 1'b0;
        end
      end else begin
        if (interrupt_mask_flag) begin
          boost_d = 1'b1;
        end
        if (fault_mask_flag && above_hard) begin
          fault_d = 1'b1;
        end
      end
    end
    if (write_valid && privileged && write_sel[7:3] == sra_pkg::GRP_MASK) begin
      unique case (write_sel[2:0])
        sra_pkg::IDX_BOOST: boost_d = write_data[0];
        sra_pkg::IDX_BASE:  base_d  = new_pri;
        sra_pkg::IDX_COND: begin
          // Only ever raises the mask; a zero value cannot disable it here.
          if (new_pri != 8'h00 &&
              (new_pri < base_q || base_q == 8'h00)) begin
            base_d = new_pri;
          end
        end
        sra_pkg::IDX_FAULT: begin
          if (above_hard) begin
            fault_d = write_data[0];
          end
        end
        sra_pkg::IDX_CTRL: begin
          ctrl_d[0] = write_data[0];
          if (!handler_mode) begin
            ctrl_d[1] = write_data[1];
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      boost_q <= sra_pkg::BOOST_RST;
      base_q  <= sra_pkg::BASE_RST;
      fault_q <= sra_pkg::FAULT_RST;
      ctrl_q  <= sra_pkg::CTRL_RST;
    end else begin
      boost_q <= boost_d;
      base_q  <= base_d;
      fault_q <= fault_d;
      ctrl_q  <= ctrl_d;
    end
  end

  // ------------------------------------------------------------
  // Special read next state
  // ------------------------------------------------------------
  always_comb begin
    rdata_d  = rdata_q;
    done_d   = read_valid;
    unpred_d = unpred_q;
    if (read_valid) begin
      rdata_d  = 32'h0000_0000;
      unpred_d = (read_dest == sra_pkg::RD_SP) || (read_dest == sra_pkg::RD_PC) ||
                 !((read_sel <= sra_pkg::SEL_FULL) ||
                   (read_sel >= sra_pkg::SEL_INT && read_sel <= sra_pkg::SEL_PSP) ||
                   (read_sel >= sra_pkg::SEL_BOOST &&
                    read_sel <= sra_pkg::SEL_CTRL));
      unique case (read_sel[7:3])
        sra_pkg::GRP_STATUS: begin
          if (read_sel[0] && privileged) begin
            rdata_d[sra_pkg::INT_HI:0] = int_status;
          end
          // Execution status fields stay zero for every status selector.
          if (!read_sel[2]) begin
            rdata_d[sra_pkg::FLAGS_HI:sra_pkg::FLAGS_LO] = flags_in;
          end
        end
        sra_pkg::GRP_STACK: begin
          if (privileged) begin
            if (read_sel[2:0] == sra_pkg::IDX_MAIN) begin
              rdata_d = main_sp;
            end else if (read_sel[2:0] == sra_pkg::IDX_PROC) begin
              rdata_d = process_sp;
            end
          end
        end
        sra_pkg::GRP_MASK: begin
          unique case (read_sel[2:0])
            sra_pkg::IDX_BOOST: rdata_d[0] = privileged && boost_q;
            sra_pkg::IDX_BASE,
            sra_pkg::IDX_COND: begin
              if (privileged) begin
                rdata_d[7:0] = base_q;
              end
            end
            sra_pkg::IDX_FAULT: rdata_d[0] = privileged && fault_q;
            sra_pkg::IDX_CTRL:  rdata_d[1:0] = ctrl_q;
            default: ;
          endcase
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q  <= 32'h0000_0000;
      done_q   <= 1'b0;
      unpred_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      done_q   <= done_d;
      unpred_q <= unpred_d;
    end
  end

  // ------------------------------------------------------------
  // Priority effects
  // ------------------------------------------------------------
  // Taken from the next mask values so the ceiling moves with the mask.
  always_comb begin
    ceil_act_d = fault_d || boost_d;
    ceil_lvl_d = sra_pkg::PRI_BOOST;
    if (fault_d) begin
      ceil_lvl_d = sra_pkg::PRI_HARD;
    end
    bmask_d = cmp_masked;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ceil_act_q <= 1'b0;
      ceil_lvl_q <= sra_pkg::PRI_BOOST;
      bmask_q    <= 1'b0;
    end else begin
      ceil_act_q <= ceil_act_d;
      ceil_lvl_q <= ceil_lvl_d;
      bmask_q    <= bmask_d;
    end
  end

  assign read_data           = rdata_q;
  assign read_done           = done_q;
  assign read_unpredictable  = unpred_q;
  assign priority_boost_mask = boost_q;
  assign base_priority_mask  = base_q;
  assign fault_level_mask    = fault_q;
  assign special_control     = ctrl_q;
  assign ceiling_active      = ceil_act_q;
  assign ceiling_level       = ceil_lvl_q;
  assign base_masking        = bmask_q;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_user_mask_hold: assert property (
    mask_change_valid && !privileged && !write_valid && !exc_return
    |=> $stable(priority_boost_mask) && $stable(fault_level_mask))
    else $error("User mask change altered a mask.");

  a_boost_clear: assert property (
    mask_change_valid && privileged && !effect_bit && interrupt_mask_flag &&
    !write_valid |=> !priority_boost_mask)
    else $error("Clear form left interrupt mask set.");

  a_boost_set: assert property (
    mask_change_valid && privileged && effect_bit && interrupt_mask_flag &&
    !write_valid |=> priority_boost_mask && ceiling_active)
    else $error("Set form did not set interrupt mask.");

  a_fault_guard: assert property (
    mask_change_valid && effect_bit && fault_mask_flag && !above_hard &&
    !write_valid && !exc_return |=> $stable(fault_level_mask))
    else $error("Fault mask set at hard fault level.");

  a_fault_ret_clear: assert property (
    exc_return && !exc_return_nmi && !mask_change_valid && !write_valid
    |=> !fault_level_mask)
    else $error("Fault mask survived exception return.");

  a_fault_ceiling: assert property (
    fault_level_mask |-> ceiling_active && ceiling_level == sra_pkg::PRI_HARD)
    else $error("Fault mask did not raise priority to -1.");

  a_unpred_dest: assert property (
    read_valid && read_dest == sra_pkg::RD_SP |=> read_done && read_unpredictable)
    else $error("Destination 13 not flagged unpredictable.");

  a_stack_user: assert property (
    read_valid && !privileged && read_sel == sra_pkg::SEL_MSP |=> read_data == 32'h0)
    else $error("User read of stack pointer not zero.");

  a_ctrl_read: assert property (
    read_valid && read_sel == sra_pkg::SEL_CTRL
    |=> read_data == {30'h0, $past(special_control)})
    else $error("Control read mismatch.");

  a_status_zero: assert property (
    read_valid && read_sel[7:3] == sra_pkg::GRP_STATUS
    |=> read_data[26:24] == 3'h0 && read_data[15:10] == 6'h00)
    else $error("Execution status bits not zero.");

  a_cond_zero: assert property (
    write_valid && write_sel == 8'h12 && write_data[7:0] == 8'h00
    |=> $stable(base_priority_mask))
    else $error("Conditional write accepted zero.");

  a_cond_raise: assert property (
    write_valid && privileged && write_sel == 8'h12 && write_data[7:0] != 8'h00 &&
    base_priority_mask == 8'h00 |=> base_priority_mask == $past(write_data[7:0]))
    else $error("Conditional write to disabled mask refused.");

endmodule : sra_unit

// >>> sra_pipe_model.sv
// Behavioural model of the decode and execute pipeline context around the unit.
`timescale 1ns/1ps

module sra_pipe_model #(
  parameter logic [4:0]  FLAGS_V = 5'h15,
  parameter logic [8:0]  INT_V   = 9'h1a5,
  parameter logic [31:0] MAIN_V  = 32'h2000_0ff0,
  parameter logic [31:0] PROC_V  = 32'h2000_1f80
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // Requested context
  input  wire logic              want_priv,
  input  wire logic              want_handler,
  input  wire logic signed [9:0] want_pri,
  // Context seen by the unit
  output logic                   privileged,
  output logic                   handler_mode,
  output logic signed [9:0]      exec_priority,
  output logic [4:0]             flags_in,
  output logic [8:0]             int_status,
  output logic [31:0]            main_sp,
  output logic [31:0]            process_sp
);
  // Context moves only at a clock edge, as a real pipeline stage would.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      privileged    <= 1'b0;
      handler_mode  <= 1'b0;
      exec_priority <= 10'sh000;
      flags_in      <= 5'h00;
      int_status    <= 9'h000;
      main_sp       <= 32'h0000_0000;
      process_sp    <= 32'h0000_0000;
    end else begin
      privileged    <= want_priv;
      handler_mode  <= want_handler;
      exec_priority <= want_pri;
      flags_in      <= FLAGS_V;
      int_status    <= INT_V;
      main_sp       <= MAIN_V;
      process_sp    <= PROC_V;
    end
  end
endmodule : sra_pipe_model

// >>> tb_top.sv
// Self-checking testbench for the special register access unit.
`timescale 1ns/1ps

module tb_top;
  localparam logic [4:0]  FLG = 5'h15;
  localparam logic [8:0]  IST = 9'h1a5;
  localparam logic [31:0] MSV = 32'h2000_0ff0;
  localparam logic [31:0] PSV = 32'h2000_1f80;

  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic mask_change_valid = 1'b0, effect_bit = 1'b0;
  logic interrupt_mask_flag = 1'b0, fault_mask_flag = 1'b0;
  logic read_valid = 1'b0, write_valid = 1'b0;
  logic [3:0] read_dest = 4'h0;
  logic [7:0] read_sel = 8'h00, write_sel = 8'h00;
  logic [31:0] write_data = 32'h0;
  logic exc_return = 1'b0, exc_return_nmi = 1'b0;
  logic [2:0] group_point = 3'h0;
  logic [7:0] stream_priority = 8'h00;
  logic want_priv = 1'b0, want_handler = 1'b0;
  logic signed [9:0] want_pri = 10'sh000;
  logic privileged, handler_mode, priority_boost_mask, fault_level_mask;
  logic signed [9:0] exec_priority, ceiling_level;
  logic [4:0] flags_in;
  logic [8:0] int_status;
  logic [31:0] main_sp, process_sp, read_data, ex;
  logic read_done, read_unpredictable, ceiling_active, base_masking;
  logic [7:0] base_priority_mask;
  logic [1:0] special_control;
  int fails = 0;
  int checks_done = 0;

  always #2 core_clk = ~core_clk;

  sra_pipe_model #(.FLAGS_V(FLG), .INT_V(IST), .MAIN_V(MSV), .PROC_V(PSV)) partner (
    .core_clk(core_clk), .reset_n(reset_n), .want_priv(want_priv),
    .want_handler(want_handler), .want_pri(want_pri), .privileged(privileged),
    .handler_mode(handler_mode), .exec_priority(exec_priority), .flags_in(flags_in),
    .int_status(int_status), .main_sp(main_sp), .process_sp(process_sp));

  sra_unit dut (
    .core_clk(core_clk), .reset_n(reset_n), .mask_change_valid(mask_change_valid),
    .effect_bit(effect_bit), .interrupt_mask_flag(interrupt_mask_flag),
    .fault_mask_flag(fault_mask_flag), .read_valid(read_valid), .read_dest(read_dest),
    .read_sel(read_sel), .write_valid(write_valid), .write_sel(write_sel),
    .write_data(write_data), .privileged(privileged), .handler_mode(handler_mode),
    .exec_priority(exec_priority), .exc_return(exc_return), .exc_return_nmi(exc_return_nmi),
    .flags_in(flags_in), .int_status(int_status), .main_sp(main_sp), .process_sp(process_sp),
    .group_point(group_point), .stream_priority(stream_priority), .read_data(read_data),
    .read_done(read_done), .read_unpredictable(read_unpredictable),
    .priority_boost_mask(priority_boost_mask), .base_priority_mask(base_priority_mask),
    .fault_level_mask(fault_level_mask), .special_control(special_control),
    .ceiling_active(ceiling_active), .ceiling_level(ceiling_level),
    .base_masking(base_masking));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic ctx(input logic p, input logic h, input logic signed [9:0] pr);
    want_priv = p;
    want_handler = h;
    want_pri = pr;
    repeat (2) @(negedge core_clk);
  endtask : ctx

  // A read is answered one cycle later and its done pulse lasts one cycle.
  task automatic rd(input logic [7:0] s, input logic [3:0] d, input logic [31:0] e,
                    input logic u);
    read_sel = s;
    read_dest = d;
    read_valid = 1'b1;
    @(negedge core_clk);
    read_valid = 1'b0;
    check({31'h0, read_done}, 32'h1);
    check(read_data, e);
    check({31'h0, read_unpredictable}, {31'h0, u});
    @(negedge core_clk);
    check({31'h0, read_done}, 32'h0);
  endtask : rd

  task automatic mc(input logic e, input logic i, input logic f);
    effect_bit = e;
    interrupt_mask_flag = i;
    fault_mask_flag = f;
    mask_change_valid = 1'b1;
    @(negedge core_clk);
    mask_change_valid = 1'b0;
    @(negedge core_clk);
  endtask : mc

  task automatic wr(input logic [7:0] s, input logic [31:0] d);
    write_sel = s;
    write_data = d;
    write_valid = 1'b1;
    @(negedge core_clk);
    write_valid = 1'b0;
    @(negedge core_clk);
  endtask : wr

  task automatic ret(input logic nmi);
    exc_return = 1'b1;
    exc_return_nmi = nmi;
    @(negedge core_clk);
    exc_return = 1'b0;
    exc_return_nmi = 1'b0;
    @(negedge core_clk);
  endtask : ret

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(negedge core_clk);
    reset_n = 1'b1;
    @(negedge core_clk);
    check({21'h0, base_priority_mask, priority_boost_mask, fault_level_mask,
           ceiling_active}, 32'h0);
    check({30'h0, special_control}, 32'h0);
    ctx(1'b1, 1'b0, 10'sh005);
    rd(8'h14, 4'h0, 32'h0, 1'b0);
    mc(1'b1, 1'b1, 1'b0);
    check({31'h0, priority_boost_mask}, 32'h1);
    check({21'h0, ceiling_active, ceiling_level}, 32'h400);
    rd(8'h10, 4'h0, 32'h1, 1'b0);
    ctx(1'b0, 1'b0, 10'sh005);
    rd(8'h10, 4'h0, 32'h0, 1'b0);
    mc(1'b0, 1'b1, 1'b0);
    check({31'h0, priority_boost_mask}, 32'h1);
    ctx(1'b1, 1'b0, 10'sh3ff);
    mc(1'b1, 1'b0, 1'b1);
    check({31'h0, fault_level_mask}, 32'h0);
    ctx(1'b1, 1'b0, 10'sh005);
    mc(1'b1, 1'b0, 1'b1);
    check({22'h0, ceiling_level}, 32'h3ff);
    rd(8'h13, 4'h0, 32'h1, 1'b0);
    mc(1'b0, 1'b1, 1'b0);
    check({30'h0, priority_boost_mask, fault_level_mask}, 32'h1);
    ret(1'b1);
    check({31'h0, fault_level_mask}, 32'h1);
    ret(1'b0);
    check({31'h0, fault_level_mask}, 32'h0);
    for (int p = 1; p >= 0; p--) begin
      ctx(p[0], 1'b0, 10'sh005);
      for (int s = 0; s < 8; s++) begin
        ex = 32'h0;
        if (s[0] && p[0]) ex[8:0] = IST;
        if (!s[2]) ex[31:27] = FLG;
        rd(s[7:0], 4'h0, ex, s == 4);
      end
      rd(8'h08, 4'h1, p[0] ? MSV : 32'h0, 1'b0);
      rd(8'h09, 4'h2, p[0] ? PSV : 32'h0, 1'b0);
    end
    rd(8'h15, 4'h0, 32'h0, 1'b1);
    rd(8'h0a, 4'h0, 32'h0, 1'b1);
    rd(8'h14, 4'hd, 32'h0, 1'b1);
    ctx(1'b1, 1'b0, 10'sh005);
    rd(8'h09, 4'hf, PSV, 1'b1);
    wr(8'h11, 32'h80);
    rd(8'h11, 4'h0, 32'h80, 1'b0);
    rd(8'h12, 4'h0, 32'h80, 1'b0);
    wr(8'h12, 32'h40);
    wr(8'h12, 32'h60);
    wr(8'h12, 32'h0);
    check({24'h0, base_priority_mask}, 32'h40);
    group_point = 3'h3;
    stream_priority = 8'h50;
    @(negedge core_clk);
    check({31'h0, base_masking}, 32'h1);
    stream_priority = 8'h4f;
    @(negedge core_clk);
    check({31'h0, base_masking}, 32'h0);
    stream_priority = 8'h30;
    @(negedge core_clk);
    check({31'h0, base_masking}, 32'h0);
    wr(8'h11, 32'h0);
    stream_priority = 8'hf0;
    @(negedge core_clk);
    check({31'h0, base_masking}, 32'h0);
    wr(8'h12, 32'h60);
    check({24'h0, base_priority_mask}, 32'h60);
    wr(8'h10, 32'h1);
    check({31'h0, priority_boost_mask}, 32'h1);
    wr(8'h13, 32'h1);
    check({31'h0, fault_level_mask}, 32'h1);
    wr(8'h13, 32'h0);
    check({31'h0, fault_level_mask}, 32'h0);
    wr(8'h14, 32'h3);
    ctx(1'b0, 1'b0, 10'sh005);
    rd(8'h14, 4'h0, 32'h3, 1'b0);
    wr(8'h11, 32'h20);
    wr(8'h10, 32'h0);
    check({23'h0, base_priority_mask, priority_boost_mask}, 32'hc1);
    ctx(1'b1, 1'b1, 10'sh005);
    wr(8'h14, 32'h0);
    check({30'h0, special_control}, 32'h2);
    ctx(1'b1, 1'b0, 10'sh3ff);
    wr(8'h13, 32'h1);
    check({31'h0, fault_level_mask}, 32'h0);
    give_verdict();
  end

  // The sequence needs well under a thousand cycles.
  initial begin
    #20000;
    fails++;
    give_verdict();
  end
endmodule : tb_top
